//--- rtl/bas_pkg.sv
/*
 * Package of the burst address sequencer: widths, configuration field
 * positions, reset values, wrap group masks, states and the state record.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package bas_pkg;

	// ----------------------------------------------------------------
	// Widths and field positions
	// ----------------------------------------------------------------
	localparam int ADDR_W = 23;
	localparam int CA_W = 48;
	localparam int CFG_W = 16;
	localparam int CA_LINEAR_BIT = 45;
	localparam int CFG_LEGACY_BIT = 2;
	localparam int CFG_LEN_LSB = 0;
	localparam int CFG_LEN_W = 2;

	// ----------------------------------------------------------------
	// Wrap length codes and group masks in words
	// ----------------------------------------------------------------
	localparam logic [CFG_LEN_W-1:0] LEN_128 = 2'h0;
	localparam logic [CFG_LEN_W-1:0] LEN_64 = 2'h1;
	localparam logic [CFG_LEN_W-1:0] LEN_16 = 2'h2;
	localparam logic [CFG_LEN_W-1:0] LEN_32 = 2'h3;
	localparam logic [ADDR_W-1:0] MASK_128 = 23'h00003F;
	localparam logic [ADDR_W-1:0] MASK_64 = 23'h00001F;
	localparam logic [ADDR_W-1:0] MASK_32 = 23'h00000F;
	localparam logic [ADDR_W-1:0] MASK_16 = 23'h000007;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 23'h000001;

	// ----------------------------------------------------------------
	// Configuration reset values
	// ----------------------------------------------------------------
	localparam logic CFG_LEGACY_RST = 1'h1;
	localparam logic [CFG_LEN_W-1:0] CFG_LEN_RST = LEN_32;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_WRAP, ST_LINEAR} bas_phase_e;

	typedef struct packed {
		bas_phase_e phase;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] start;
		logic [ADDR_W-1:0] mask;
		logic hybrid;
		logic cfgLegacy;
		logic [CFG_LEN_W-1:0] cfgLen;
		logic cfgSeen;
		logic ckPrev;
		logic valid;
		logic wrapPh;
	} bas_state_s;

	localparam bas_state_s STATE_RST = '{
		phase: ST_IDLE,
		addr: '0,
		start: '0,
		mask: MASK_32,
		hybrid: 1'h0,
		cfgLegacy: CFG_LEGACY_RST,
		cfgLen: CFG_LEN_RST,
		cfgSeen: 1'h0,
		ckPrev: 1'h0,
		valid: 1'h0,
		wrapPh: 1'h0
	};

	function automatic logic [ADDR_W-1:0] maskOf(input logic [CFG_LEN_W-1:0] len);
		logic [ADDR_W-1:0] m;
		m = MASK_32;
		case (len)
			LEN_128: m = MASK_128;
			LEN_64: m = MASK_64;
			LEN_16: m = MASK_16;
			default: m = MASK_32;
		endcase
		return m;
	endfunction

endpackage

`default_nettype wire

//--- rtl/bas_sync2.sv
/*
 * Two flip-flop synchroniser for a bus of independent levels.
 * Assumes clk_sys is the destination clock and clkEn freezes it.
 */
`timescale 1ns/10ps
`default_nettype none

module bas_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} bas_sync_s;

	bas_sync_s s_r;
	bas_sync_s s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.held = s_r.meta;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (clkEn) begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.held;

endmodule // bas_sync2

`default_nettype wire

//--- rtl/bas_burst_address_sequencer.sv
/*
 * Burst address sequencer: produces the word order of one array burst.
 * Assumes linkCk and csN are raw pins; startWord, commandAddressWord,
 * burstConfigReg and cfgLoad come from clk_sys logic, steady when csN falls.
 */
// What this block does
// - Hybrid: walk the whole aligned group from the start word, then next group.
// - After the hybrid wrap, count linearly until chip select goes high.
// - Config bit 2: 0 hybrid, 1 legacy wrap; resets to 1.
// - Length code 00/01/10/11 gives 128/64/16/32 byte groups.
// - Words wrap inside a size-aligned group: 2E..3F, 20..2D for 64 bytes.
// - A 16-byte group is eight words: 0C..0F then 08..0B.
// - Hybrid 16 from 0C finishes its group, then goes on at 10.
// - Hybrid 64 from 2E finishes at 2D, then goes on at 40.
// - Hybrid 128 from 03 runs to 3F, 00..02, then goes on at 40.
// - Command bit 45 set means plain linear burst, ignoring the wrap setup.
// - Legacy wrap keeps cycling inside its group while the burst lasts.
`timescale 1ns/10ps
`default_nettype none

module bas_burst_address_sequencer (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic linkCk,
	input wire logic csN,
	input wire logic [bas_pkg::CA_W-1:0] commandAddressWord,
	input wire logic [bas_pkg::ADDR_W-1:0] startWord,
	input wire logic [bas_pkg::CFG_W-1:0] burstConfigReg,
	input wire logic cfgLoad,
	output logic [bas_pkg::ADDR_W-1:0] wordAddr,
	output logic addrValid,
	output logic wrapPhase
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pinSync;
	logic ckSync;
	logic csHigh;

	bas_sync2 #(.W(2)) uPinSync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clkEn(clkEn),
		.d({linkCk, ~csN}),
		.q(pinSync)
	);

	assign ckSync = pinSync[1];
	// Chip select enters inverted: a cleared synchroniser reads as no burst
	assign csHigh = !pinSync[0];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	bas_pkg::bas_state_s s_r;
	bas_pkg::bas_state_s s_nxt;
	logic ckRise;
	logic [bas_pkg::ADDR_W-1:0] wrapNext;
	logic [bas_pkg::ADDR_W-1:0] nextGroup;
	logic wrapDone;
	logic stepNow;
	logic burstBegin;

	always_comb begin
		ckRise = ckSync && !s_r.ckPrev;
		stepNow = clkEn && !csHigh && (s_r.phase != bas_pkg::ST_IDLE) && ckRise;
		burstBegin = clkEn && !csHigh && (s_r.phase == bas_pkg::ST_IDLE);
		// Next word inside the aligned group
		wrapNext = (s_r.addr & ~s_r.mask) | ((s_r.addr + bas_pkg::ADDR_ONE) & s_r.mask);
		wrapDone = ((wrapNext ^ s_r.start) & s_r.mask) == '0;
		nextGroup = (s_r.addr & ~s_r.mask) + s_r.mask + bas_pkg::ADDR_ONE;

		s_nxt = s_r;
		s_nxt.ckPrev = ckSync;
		if (cfgLoad) begin
			s_nxt.cfgLegacy = burstConfigReg[bas_pkg::CFG_LEGACY_BIT];
			s_nxt.cfgLen = burstConfigReg[bas_pkg::CFG_LEN_LSB +: bas_pkg::CFG_LEN_W];
			s_nxt.cfgSeen = 1'h1;
		end
		if (csHigh) begin
			// Burst over: address held, output invalid
			s_nxt.phase = bas_pkg::ST_IDLE;
			s_nxt.valid = 1'h0;
			s_nxt.wrapPh = 1'h0;
		end else begin
			case (s_r.phase)
				bas_pkg::ST_IDLE: begin
					s_nxt.addr = startWord;
					s_nxt.start = startWord;
					s_nxt.mask = bas_pkg::maskOf(s_r.cfgLen);
					s_nxt.hybrid = !s_r.cfgLegacy;
					s_nxt.valid = 1'h1;
					if (commandAddressWord[bas_pkg::CA_LINEAR_BIT]) begin
						s_nxt.phase = bas_pkg::ST_LINEAR;
						s_nxt.wrapPh = 1'h0;
					end else begin
						s_nxt.phase = bas_pkg::ST_WRAP;
						s_nxt.wrapPh = 1'h1;
					end
				end
				bas_pkg::ST_WRAP: begin
					if (ckRise) begin
						if (s_r.hybrid && wrapDone) begin
							s_nxt.addr = nextGroup;
							s_nxt.phase = bas_pkg::ST_LINEAR;
							s_nxt.wrapPh = 1'h0;
						end else begin
							s_nxt.addr = wrapNext;
						end
					end
				end
				bas_pkg::ST_LINEAR: begin
					if (ckRise) begin
						s_nxt.addr = s_r.addr + bas_pkg::ADDR_ONE;
					end
				end
				default: begin
					s_nxt.phase = bas_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_r <= bas_pkg::STATE_RST;
		end else if (clkEn) begin
			s_r <= s_nxt;
		end
	end

	assign wordAddr = s_r.addr;
	assign addrValid = s_r.valid;
	assign wrapPhase = s_r.wrapPh;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Burst start, hybrid exit and linear step
	a_start_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		burstBegin |=> addrValid && wordAddr == $past(startWord)
		&& wrapPhase == !$past(commandAddressWord[bas_pkg::CA_LINEAR_BIT]))
		else $error("burst did not open at its start word");

	a_hybrid_jump: assert property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.phase == bas_pkg::ST_WRAP && s_r.hybrid && wrapDone
		|=> wordAddr == $past(nextGroup) && s_r.phase == bas_pkg::ST_LINEAR)
		else $error("hybrid burst did not move to the next group");

	a_linear_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.phase == bas_pkg::ST_LINEAR
		|=> wordAddr == $past(wordAddr) + bas_pkg::ADDR_ONE)
		else $error("linear burst did not step by one word");

	// Configuration
	a_cfg_default: assert property (@(posedge clk_sys) disable iff (!resetn)
		!s_r.cfgSeen
		|-> s_r.cfgLegacy && s_r.cfgLen == bas_pkg::CFG_LEN_RST)
		else $error("configuration left its reset value unloaded");

	a_cfg_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		clkEn && cfgLoad
		|=> s_r.cfgLegacy == $past(burstConfigReg[bas_pkg::CFG_LEGACY_BIT])
		&& s_r.cfgLen == $past(burstConfigReg[bas_pkg::CFG_LEN_LSB +: bas_pkg::CFG_LEN_W]))
		else $error("configuration word not captured on load");

	a_mask_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
		burstBegin && s_r.cfgLen == bas_pkg::LEN_16
		|=> s_r.mask == bas_pkg::MASK_16 && s_r.start == $past(startWord))
		else $error("16-byte group mask not taken");

	// Wrap order and linear command
	a_wrap_order: assert property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.phase == bas_pkg::ST_WRAP && !(s_r.hybrid && wrapDone)
		|=> (wordAddr & s_r.mask) == (($past(wordAddr) + bas_pkg::ADDR_ONE) & s_r.mask))
		else $error("wrap did not take the next word in its group");

	a_group_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.phase == bas_pkg::ST_WRAP && !s_r.hybrid
		|=> (wordAddr & ~s_r.mask) == ($past(wordAddr) & ~s_r.mask))
		else $error("legacy wrap left its aligned group");

	a_legacy_stay: assert property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.phase == bas_pkg::ST_WRAP && !s_r.hybrid
		|=> s_r.phase == bas_pkg::ST_WRAP && wrapPhase)
		else $error("legacy wrap left its wrap phase");

	a_linear_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
		burstBegin && commandAddressWord[bas_pkg::CA_LINEAR_BIT]
		|=> s_r.phase == bas_pkg::ST_LINEAR && !wrapPhase && addrValid)
		else $error("linear command did not start a linear burst");

	// Chip select, link edges and clock enable
	a_cs_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		clkEn && csHigh |=> !addrValid && $stable(wordAddr))
		else $error("address moved or stayed valid with chip select high");

	a_no_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
		clkEn && !ckRise && s_r.phase != bas_pkg::ST_IDLE |=> $stable(wordAddr))
		else $error("address moved without a link clock edge");

	a_idle_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_r.phase == bas_pkg::ST_IDLE |-> !addrValid && !wrapPhase)
		else $error("idle sequencer shows a valid or wrapping address");

	a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		!clkEn |=> $stable(wordAddr) && $stable(addrValid) && $stable(wrapPhase))
		else $error("outputs moved while the clock enable was low");

	// Main scenarios
	c_hybrid_jump: cover property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && s_r.hybrid && wrapDone && s_r.phase == bas_pkg::ST_WRAP);

	c_legacy_wrap: cover property (@(posedge clk_sys) disable iff (!resetn)
		stepNow && !s_r.hybrid && wrapDone && s_r.phase == bas_pkg::ST_WRAP);

	c_linear_run: cover property (@(posedge clk_sys) disable iff (!resetn)
		burstBegin && commandAddressWord[bas_pkg::CA_LINEAR_BIT]);

	c_legacy_128: cover property (@(posedge clk_sys) disable iff (!resetn)
		burstBegin && s_r.cfgLegacy && s_r.cfgLen == bas_pkg::LEN_128);

	c_freeze: cover property (@(posedge clk_sys) disable iff (!resetn)
		addrValid && !clkEn);

endmodule // bas_burst_address_sequencer

`default_nettype wire

//--- verif/bas_host_model.sv
/*
 * Host controller model: drives chip select and the link clock.
 * Assumes the bench calls its tasks at falling clk_sys edges.
 */
`timescale 1ns/10ps
`default_nettype none

module bas_host_model (
	input wire logic clk_sys,
	output logic csN,
	output logic linkCk
);
	// Link clock starts low and chip select starts high
	initial begin
		csN = 1'h1;
		linkCk = 1'h0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic open_burst();
		@(negedge clk_sys);
		csN = 1'h0;
		wait_n(4);
	endtask

	// One 400 ns link period, four clk_sys cycles per level
	task automatic pulse();
		linkCk = 1'h1;
		wait_n(4);
		linkCk = 1'h0;
		wait_n(4);
	endtask

	task automatic close_burst();
		csN = 1'h1;
		wait_n(4);
	endtask
endmodule // bas_host_model

`default_nettype wire

//--- verif/bas_burst_address_sequencer_tb_top.sv
/*
 * Bench of the burst address sequencer: wrapped, hybrid and linear orders.
 * Assumes the host model drives chip select and the link clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bas_burst_address_sequencer_tb_top;
	logic clk_sys, resetn, clkEn, cfgLoad, addrValid, wrapPhase;
	logic [bas_pkg::CA_W-1:0] caWord;
	logic [bas_pkg::ADDR_W-1:0] startWord, wordAddr;
	logic [bas_pkg::CFG_W-1:0] cfgWord;
	wire logic csN;
	wire logic linkCk;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [22:0] grpMask [4] = '{23'h00003F, 23'h00001F, 23'h000007, 23'h00000F};

	bas_host_model i_host (.clk_sys(clk_sys), .csN(csN), .linkCk(linkCk));

	bas_burst_address_sequencer i_dut (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clkEn(clkEn),
		.linkCk(linkCk),
		.csN(csN),
		.commandAddressWord(caWord),
		.startWord(startWord),
		.burstConfigReg(cfgWord),
		.cfgLoad(cfgLoad),
		.wordAddr(wordAddr),
		.addrValid(addrValid),
		.wrapPhase(wrapPhase)
	);

	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Counts: tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Expected order worked out step by step; word k is also held against v
	task automatic run_burst(input logic ld, input logic [2:0] cfg, input logic lin,
			input logic [22:0] s, input int n, input int k, input logic [22:0] v);
		logic [22:0] e, m, w;
		logic ph;
		m = grpMask[cfg[1:0]];
		e = s;
		ph = !lin;
		@(negedge clk_sys);
		cfgWord = {13'h0000, cfg};
		cfgLoad = ld;
		@(negedge clk_sys);
		cfgLoad = 1'h0;
		startWord = s;
		caWord = {2'h0, lin, 45'h0};
		i_host.open_burst();
		for (int i = 0; i < n; i++) begin
			chk({9'h000, wordAddr}, {9'h000, e});
			if (i == k) begin
				chk({9'h000, wordAddr}, {9'h000, v});
			end
			chk({30'h0, addrValid, wrapPhase}, {30'h0, 1'h1, ph});
			i_host.pulse();
			if (lin || !ph) begin
				e = e + 23'h000001;
			end else begin
				w = (e & ~m) | ((e + 23'h000001) & m);
				if (!cfg[2] && w == s) begin
					e = (e & ~m) + m + 23'h000001;
					ph = 1'h0;
				end else begin
					e = w;
				end
			end
		end
		i_host.close_burst();
		chk({31'h0, addrValid}, 32'h0);
		chk({9'h000, wordAddr}, {9'h000, e});
		// Link edge outside a frame must be ignored
		i_host.pulse();
		chk({9'h000, wordAddr}, {9'h000, e});
	endtask

	// Reset in mid-run: outputs clear, configuration returns to legacy 32
	task automatic reset_mid();
		@(negedge clk_sys);
		resetn = 1'h0;
		repeat (2) @(negedge clk_sys);
		chk({30'h0, addrValid, wrapPhase}, 32'h0);
		resetn = 1'h1;
		repeat (3) @(negedge clk_sys);
		chk({9'h000, wordAddr}, 32'h0);
		chk({30'h0, addrValid, wrapPhase}, 32'h0);
	endtask

	// Link edges while the clock enable is low must be lost
	task automatic freeze_burst();
		@(negedge clk_sys);
		startWord = 23'h00000A;
		caWord = 48'h0;
		i_host.open_burst();
		chk({9'h000, wordAddr}, 32'h0000000A);
		clkEn = 1'h0;
		i_host.pulse();
		i_host.pulse();
		chk({9'h000, wordAddr}, 32'h0000000A);
		chk({31'h0, addrValid}, 32'h1);
		clkEn = 1'h1;
		i_host.pulse();
		chk({9'h000, wordAddr}, 32'h0000000B);
		i_host.close_burst();
		chk({31'h0, addrValid}, 32'h0);
	endtask

	initial begin
		resetn = 1'h0;
		clkEn = 1'h1;
		cfgLoad = 1'h0;
		cfgWord = 16'h0000;
		caWord = 48'h0;
		startWord = 23'h000000;
		repeat (8) @(negedge clk_sys);
		resetn = 1'h1;
		repeat (6) @(negedge clk_sys);
		chk({9'h000, wordAddr}, 32'h0);
		chk({30'h0, addrValid, wrapPhase}, 32'h0);
		run_burst(1'h0, 3'h7, 1'h0, 23'h00001E, 20, 2, 23'h000010);
		run_burst(1'h1, 3'h2, 1'h0, 23'h00000C, 12, 8, 23'h000010);
		run_burst(1'h1, 3'h1, 1'h0, 23'h00002E, 40, 32, 23'h000040);
		run_burst(1'h1, 3'h0, 1'h0, 23'h000003, 70, 64, 23'h000040);
		run_burst(1'h1, 3'h6, 1'h0, 23'h00000C, 20, 8, 23'h00000C);
		run_burst(1'h1, 3'h5, 1'h0, 23'h00002E, 36, 18, 23'h000020);
		run_burst(1'h1, 3'h3, 1'h0, 23'h00001E, 20, 16, 23'h000020);
		run_burst(1'h1, 3'h4, 1'h0, 23'h000003, 66, 64, 23'h000003);
		run_burst(1'h1, 3'h2, 1'h1, 23'h7FFFFE, 5, 2, 23'h000000);
		reset_mid();
		run_burst(1'h0, 3'h7, 1'h0, 23'h00000A, 18, 16, 23'h00000A);
		freeze_burst();
		final_report();
	end
endmodule // bas_burst_address_sequencer_tb_top

`default_nettype wire
